// ### shared/dat_pkg.sv
// Constants shared by the digitizer acquisition timing engine.
// Assumes a single timebase clock domain and a plain register port.
package dat_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] DAT_REG_CTRL     = 4'h0;
  localparam logic [3:0] DAT_REG_INTERVAL = 4'h1;
  localparam logic [3:0] DAT_REG_COUNT    = 4'h2;
  localparam logic [3:0] DAT_REG_DELAY    = 4'h3;
  localparam logic [3:0] DAT_REG_RETRIG   = 4'h4;
  localparam logic [3:0] DAT_REG_STATUS   = 4'h5;
  localparam logic [3:0] DAT_REG_CAPTURED = 4'h6;
  localparam logic [3:0] DAT_REG_TRACES   = 4'h7;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int DAT_CTRL_START_BIT   = 0;  // Write one: arm acquisition.
  localparam int DAT_CTRL_SWTRIG_BIT  = 1;  // Write one: software trigger.
  localparam int DAT_CTRL_ABORT_BIT   = 2;  // Write one: return to idle.
  localparam int DAT_CTRL_EXTEN_BIT   = 3;  // External trigger input enable.
  localparam int DAT_CTRL_EXTPOL_BIT  = 4;  // One selects falling edge.
  localparam int DAT_CTRL_SYNCIN_BIT  = 5;  // Sync pin acts as trigger source.
  localparam int DAT_CTRL_SYNCOUT_BIT = 6;  // Sync pin driven by this card.
  localparam int DAT_CTRL_DELAYED_BIT = 7;  // Delayed trigger mode.
  localparam int DAT_CTRL_WIDTH       = 8;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int DAT_STAT_STATE_LSB = 0;   // Four one-hot state bits.
  localparam int DAT_STAT_EMPTY_BIT = 4;
  localparam int DAT_STAT_FULL_BIT  = 5;
  localparam int DAT_STAT_CARD_LSB  = 8;   // Four card number bits.
  localparam int DAT_STAT_RECOV_BIT = 12;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] DAT_INTERVAL_RST = 16'h0001;
  localparam logic [31:0] DAT_COUNT_RST    = 32'h0000_0100;
  localparam logic [15:0] DAT_DELAY_RST    = 16'h0001;
  localparam logic [30:0] DAT_RETRIG_RST   = 31'h0000_0001;
  localparam logic [DAT_CTRL_WIDTH-1:0] DAT_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    DAT_IDLE    = 4'b0001,
    DAT_ARMED   = 4'b0010,
    DAT_DELAY   = 4'b0100,
    DAT_CAPTURE = 4'b1000
  } dat_state_t;

endpackage

// ### hw/dat_engine.sv
// Acquisition timing engine: trigger selection, delay, interval pacing,
// sample counting, retrigger handling and an onboard sample FIFO.
// Assumes all inputs are synchronous to core_clk_in, the timebase clock.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module dat_engine
  import dat_pkg::*;
#(
  parameter int DATA_W  = 64,   // Four 16-bit channels per sample.
  parameter int DEPTH_W = 4     // FIFO holds 2**DEPTH_W samples.
) (
  input  wire logic              core_clk_in,           // Timebase clock.
  input  wire logic              rstn_in,               // Async reset, low.
  input  wire logic [3:0]        reg_addr_in,           // Register index.
  input  wire logic [31:0]       reg_wdata_in,          // Write data.
  input  wire logic              reg_wr_in,             // Write strobe.
  input  wire logic              reg_rd_in,             // Read strobe.
  output logic      [31:0]       reg_rdata_out,         // Read data.
  input  wire logic [DATA_W-1:0] adc_data_in,           // Converted sample.
  input  wire logic              external_trigger_input_in, // Front trigger.
  input  wire logic              sync_bus_trigger_pin_in,   // Pin level.
  output logic                   sync_bus_trigger_pin_out,  // Pin drive.
  output logic                   sync_bus_trigger_pin_oe_out, // Drive enable.
  input  wire logic [3:0]        card_switch_in,        // Slider 1 at bit 3.
  input  wire logic              flash_config_switch_in, // On is one.
  output logic                   recovery_boot_out,     // Recovery selected.
  output logic [DATA_W-1:0]      dma_data_out,          // Head sample.
  output logic                   dma_valid_out,         // Head is valid.
  input  wire logic              dma_ready_in,          // DMA accepts head.
  output logic                   sample_strobe_out      // Sample taken.
);

  localparam int DEPTH = 1 << DEPTH_W;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dat_state_t          state_reg, state_next;
  logic [DAT_CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
  logic [15:0]         interval_reg, interval_next;
  logic [31:0]         count_reg, count_next;
  logic [15:0]         delay_reg, delay_next;
  logic [30:0]         retrig_reg, retrig_next;
  logic [15:0]         tick_reg, tick_next;
  logic [31:0]         captured_reg, captured_next;
  logic [30:0]         traces_reg, traces_next;
  logic                ext_q_reg, sync_q_reg;
  logic                trig_pulse_reg, trig_pulse_next;
  logic                strobe_reg, strobe_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic [3:0]          card_reg;
  logic                recov_reg;
  logic [DATA_W-1:0]   mem [DEPTH];
  logic [DEPTH_W:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [DATA_W-1:0]   head_reg;
  logic                hvalid_reg, hvalid_next;

  // Trigger sources and control decode.
  logic ext_edge, sync_edge, trig_event, start_cmd, abort_cmd, sw_trig;
  logic fifo_empty, fifo_full, do_write, do_read, take;
  logic ctrl_wr;

  assign ctrl_wr   = reg_wr_in && (reg_addr_in == DAT_REG_CTRL);
  assign start_cmd = ctrl_wr && reg_wdata_in[DAT_CTRL_START_BIT];
  assign abort_cmd = ctrl_wr && reg_wdata_in[DAT_CTRL_ABORT_BIT];
  assign sw_trig   = ctrl_wr && reg_wdata_in[DAT_CTRL_SWTRIG_BIT];

  // Edge detection on the external input follows the selected polarity.
  assign ext_edge = ctrl_reg[DAT_CTRL_EXTEN_BIT] &&
                    (ctrl_reg[DAT_CTRL_EXTPOL_BIT] ?
                     (ext_q_reg && !external_trigger_input_in) :
                     (!ext_q_reg && external_trigger_input_in));
  // The sync pin only triggers on a rising edge when it is an input.
  assign sync_edge = ctrl_reg[DAT_CTRL_SYNCIN_BIT] &&
                     !ctrl_reg[DAT_CTRL_SYNCOUT_BIT] &&
                     !sync_q_reg && sync_bus_trigger_pin_in;
  assign trig_event = sw_trig || ext_edge || sync_edge;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Software writes configuration; divider and delay zero are clamped to one.
  always_comb begin
    ctrl_next     = ctrl_reg;
    interval_next = interval_reg;
    count_next    = count_reg;
    delay_next    = delay_reg;
    retrig_next   = retrig_reg;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        DAT_REG_CTRL: begin
          ctrl_next = reg_wdata_in[DAT_CTRL_WIDTH-1:0];
          ctrl_next[DAT_CTRL_START_BIT]  = 1'b0;
          ctrl_next[DAT_CTRL_SWTRIG_BIT] = 1'b0;
          ctrl_next[DAT_CTRL_ABORT_BIT]  = 1'b0;
        end
        DAT_REG_INTERVAL: begin
          interval_next = (reg_wdata_in[15:0] == 16'h0000) ? 16'h0001
                          : reg_wdata_in[15:0];
        end
        DAT_REG_COUNT: begin
          // A full 32-bit value allows up to 4294967295 samples per trace.
          count_next = (reg_wdata_in == 32'h0000_0000) ? 32'h0000_0001
                       : reg_wdata_in;
        end
        DAT_REG_DELAY: begin
          delay_next = (reg_wdata_in[15:0] == 16'h0000) ? 16'h0001
                       : reg_wdata_in[15:0];
        end
        DAT_REG_RETRIG: begin
          retrig_next = (reg_wdata_in[30:0] == 31'h0000_0000) ? 31'h0000_0001
                        : reg_wdata_in[30:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses return zero.
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_in) begin
      rdata_next = 32'h0000_0000;
      unique case (reg_addr_in)
        DAT_REG_CTRL:     rdata_next[DAT_CTRL_WIDTH-1:0] = ctrl_reg;
        DAT_REG_INTERVAL: rdata_next[15:0] = interval_reg;
        DAT_REG_COUNT:    rdata_next = count_reg;
        DAT_REG_DELAY:    rdata_next[15:0] = delay_reg;
        DAT_REG_RETRIG:   rdata_next[30:0] = retrig_reg;
        DAT_REG_STATUS: begin
          rdata_next[DAT_STAT_STATE_LSB +: 4] = state_reg;
          rdata_next[DAT_STAT_EMPTY_BIT] = fifo_empty;
          rdata_next[DAT_STAT_FULL_BIT]  = fifo_full;
          rdata_next[DAT_STAT_CARD_LSB +: 4] = card_reg;
          rdata_next[DAT_STAT_RECOV_BIT] = recov_reg;
        end
        DAT_REG_CAPTURED: rdata_next = captured_reg;
        DAT_REG_TRACES:   rdata_next[30:0] = traces_reg;
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Acquisition state machine
  // ----------------------------------------------------------------------
  // Triggers are only seen in ARMED, so those landing inside a trace or its
  // delay are ignored; the minimum spacing follows from the trace length.
  always_comb begin
    state_next      = state_reg;
    tick_next       = tick_reg;
    captured_next   = captured_reg;
    traces_next     = traces_reg;
    trig_pulse_next = 1'b0;
    strobe_next     = 1'b0;
    take            = 1'b0;
    if (abort_cmd) begin
      state_next = DAT_IDLE;
    end else begin
      unique case (state_reg)
        DAT_IDLE: begin
          if (start_cmd) begin
            state_next    = DAT_ARMED;
            captured_next = 32'h0000_0000;
            traces_next   = 31'h0000_0000;
          end
        end
        DAT_ARMED: begin
          if (trig_event) begin
            trig_pulse_next = 1'b1;
            tick_next       = 16'h0001;
            if (ctrl_reg[DAT_CTRL_DELAYED_BIT]) begin
              state_next = DAT_DELAY;
            end else begin
              state_next = DAT_CAPTURE;
              tick_next  = 16'h0000;
            end
          end
        end
        DAT_DELAY: begin
          // One timebase period per delay count.
          if (tick_reg >= delay_reg) begin
            state_next = DAT_CAPTURE;
            tick_next  = 16'h0000;
          end else begin
            tick_next = tick_reg + 16'h0001;
          end
        end
        DAT_CAPTURE: begin
          // Interval counter paces samples; divider one samples every cycle.
          if (tick_reg == 16'h0000) begin
            take          = !fifo_full;
            strobe_next   = 1'b1;
            captured_next = captured_reg + 32'h0000_0001;
            if (captured_next == count_reg) begin
              traces_next = traces_reg + 31'h0000_0001;
              state_next  = (traces_next == retrig_reg) ? DAT_IDLE
                            : DAT_ARMED;
              captured_next = 32'h0000_0000;
            end
          end
          tick_next = (tick_reg + 16'h0001 >= interval_reg) ? 16'h0000
                      : tick_reg + 16'h0001;
        end
        default: state_next = DAT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sample FIFO with a registered head toward DMA
  // ----------------------------------------------------------------------
  assign fifo_empty = (wptr_reg == rptr_reg);
  assign fifo_full  = (wptr_reg[DEPTH_W] != rptr_reg[DEPTH_W]) &&
                      (wptr_reg[DEPTH_W-1:0] == rptr_reg[DEPTH_W-1:0]);
  assign do_write   = take;
  assign do_read    = !fifo_empty && (!hvalid_reg || dma_ready_in);

  // Pointer and head-valid update.
  always_comb begin
    wptr_next   = do_write ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next   = do_read ? rptr_reg + 1'b1 : rptr_reg;
    hvalid_next = do_read ? 1'b1 : (dma_ready_in ? 1'b0 : hvalid_reg);
  end

  // Sample storage; no reset needed on data.
  always_ff @(posedge core_clk_in) begin
    if (do_write) begin
      mem[wptr_reg[DEPTH_W-1:0]] <= adc_data_in;
    end
    if (do_read) begin
      head_reg <= mem[rptr_reg[DEPTH_W-1:0]];
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // All control state.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg      <= DAT_IDLE;
      ctrl_reg       <= DAT_CTRL_RST;
      interval_reg   <= DAT_INTERVAL_RST;
      count_reg      <= DAT_COUNT_RST;
      delay_reg      <= DAT_DELAY_RST;
      retrig_reg     <= DAT_RETRIG_RST;
      tick_reg       <= 16'h0000;
      captured_reg   <= 32'h0000_0000;
      traces_reg     <= 31'h0000_0000;
      ext_q_reg      <= 1'b0;
      sync_q_reg     <= 1'b0;
      trig_pulse_reg <= 1'b0;
      strobe_reg     <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      card_reg       <= 4'hF;
      recov_reg      <= 1'b0;
      wptr_reg       <= '0;
      rptr_reg       <= '0;
      hvalid_reg     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      ctrl_reg       <= ctrl_next;
      interval_reg   <= interval_next;
      count_reg      <= count_next;
      delay_reg      <= delay_next;
      retrig_reg     <= retrig_next;
      tick_reg       <= tick_next;
      captured_reg   <= captured_next;
      traces_reg     <= traces_next;
      ext_q_reg      <= external_trigger_input_in;
      sync_q_reg     <= sync_bus_trigger_pin_in;
      trig_pulse_reg <= trig_pulse_next;
      strobe_reg     <= strobe_next;
      rdata_reg      <= rdata_next;
      card_reg       <= card_switch_in;
      recov_reg      <= flash_config_switch_in;
      wptr_reg       <= wptr_next;
      rptr_reg       <= rptr_next;
      hvalid_reg     <= hvalid_next;
    end
  end

  // Outputs straight from flip-flops. Driving only when set as output keeps
  // a single source on the shared line.
  assign reg_rdata_out               = rdata_reg;
  assign sync_bus_trigger_pin_out    = trig_pulse_reg;
  assign sync_bus_trigger_pin_oe_out = ctrl_reg[DAT_CTRL_SYNCOUT_BIT];
  assign recovery_boot_out           = recov_reg;
  assign dma_data_out                = head_reg;
  assign dma_valid_out               = hvalid_reg;
  assign sample_strobe_out           = strobe_reg;

endmodule

`default_nettype wire

// ### verif/dat_engine_checker.sv
// Concurrent checks on the acquisition timing engine ports.
// Assumes it is bound into every instance of dat_engine.
`timescale 1ns/1ns
`default_nettype none

module dat_engine_checker
  import dat_pkg::*;
#(
  parameter int DATA_W = 64
) (
  input wire logic              core_clk_in,                 // Timebase clock.
  input wire logic              rstn_in,                     // Async reset, low.
  input wire logic [3:0]        reg_addr_in,                 // Register index.
  input wire logic [31:0]       reg_wdata_in,                // Write data.
  input wire logic              reg_wr_in,                   // Write strobe.
  input wire logic              flash_config_switch_in,      // Recovery switch.
  input wire logic              recovery_boot_out,           // Recovery selected.
  input wire logic              sync_bus_trigger_pin_out,    // Sync pin drive.
  input wire logic              sync_bus_trigger_pin_oe_out, // Sync pin enable.
  input wire logic              sample_strobe_out,           // Sample taken.
  input wire logic [DATA_W-1:0] dma_data_out,                // Head sample.
  input wire logic              dma_valid_out,               // Head valid.
  input wire logic              dma_ready_in                 // DMA accepts.
);
  // ----------------------------------------------------------------------
  // Shadow of the pacing setup and a settle count after reset
  // ----------------------------------------------------------------------
  logic [15:0] intv_reg;
  logic        dly_reg;
  logic [1:0]  live_reg;

  // Tracks interval and delayed mode as software writes them.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      intv_reg <= DAT_INTERVAL_RST;
      dly_reg  <= 1'b0;
      live_reg <= 2'h0;
    end else begin
      if (live_reg != 2'h3) live_reg <= live_reg + 2'h1;
      if (reg_wr_in && reg_addr_in == DAT_REG_INTERVAL) intv_reg <= reg_wdata_in[15:0];
      if (reg_wr_in && reg_addr_in == DAT_REG_CTRL) begin
        dly_reg <= reg_wdata_in[DAT_CTRL_DELAYED_BIT];
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  recovery_follow_a: assert property (
    live_reg == 2'h3 |-> recovery_boot_out == $past(flash_config_switch_in))
    else $error("recovery output does not follow the switch");
  sync_dir_a: assert property (
    reg_wr_in && reg_addr_in == DAT_REG_CTRL
    |=> sync_bus_trigger_pin_oe_out == $past(reg_wdata_in[DAT_CTRL_SYNCOUT_BIT]))
    else $error("sync pin direction does not follow control");
  sync_pulse_a: assert property (
    sync_bus_trigger_pin_out |=> !sync_bus_trigger_pin_out)
    else $error("sync trigger pulse longer than one cycle");
  post_first_a: assert property (
    sync_bus_trigger_pin_out && !dly_reg |=> sample_strobe_out)
    else $error("post mode first sample not immediate");
  delay_hold_a: assert property (
    sync_bus_trigger_pin_out && dly_reg |=> !sample_strobe_out)
    else $error("delayed mode sampled too early");
  slow_rate_a: assert property (
    sample_strobe_out && intv_reg > 16'h0001 |=> !sample_strobe_out)
    else $error("samples closer than the interval");
  fifo_push_a: assert property (
    sample_strobe_out |=> dma_valid_out)
    else $error("sample not offered to the DMA path");
  hold_head_a: assert property (
    dma_valid_out && !dma_ready_in |=> dma_valid_out && $stable(dma_data_out))
    else $error("head sample dropped while stalled");
endmodule

bind dat_engine dat_engine_checker #(.DATA_W(DATA_W)) chk_i (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .flash_config_switch_in(flash_config_switch_in), .recovery_boot_out(recovery_boot_out),
  .sync_bus_trigger_pin_out(sync_bus_trigger_pin_out),
  .sync_bus_trigger_pin_oe_out(sync_bus_trigger_pin_oe_out),
  .sample_strobe_out(sample_strobe_out), .dma_data_out(dma_data_out),
  .dma_valid_out(dma_valid_out), .dma_ready_in(dma_ready_in));

`default_nettype wire

// ### verif/dat_far_end.sv
// Far side model: a DMA sink that can stall, and a peer card on the sync line.
// Assumes the bench drives stall and peer requests after clock edges.
`timescale 1ns/1ns
`default_nettype none

module dat_far_end (
  input  wire logic        clk_in,          // Timebase clock.
  input  wire logic        rstn_in,         // Async reset, low.
  input  wire logic [63:0] dma_data_in,     // Head sample.
  input  wire logic        dma_valid_in,    // Head valid.
  input  wire logic        stall_in,        // Slow acceptance.
  input  wire logic        peer_fire_in,    // Peer drives a high level.
  input  wire logic        dut_oe_in,       // Engine drives the line.
  input  wire logic        dut_pin_in,      // Engine pin level.
  output logic             dma_ready_out,   // Sink accepts.
  output logic             sync_line_out    // Resolved line level.
);
  logic [1:0]  ph_reg;
  logic [63:0] got[$];

  // Collects every word taken; when stalling, accepts one cycle in four.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      if (dma_valid_in && dma_ready_out) got.push_back(dma_data_in);
    end
  end
  assign dma_ready_out = !stall_in || ph_reg == 2'h0;

  // The peer stays a slave while the engine drives; released line follows the peer.
  assign sync_line_out = dut_oe_in ? dut_pin_in : peer_fire_in;
endmodule

`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the acquisition timing engine.
// Assumes dat_engine, its checker and the far side model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import dat_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  logic [63:0] adc = 64'h0;
  logic        ext = 1'b0;
  logic        line, pin_out, oe, recov, dma_valid, dma_ready, strobe;
  logic [3:0]  card = 4'hF;
  logic        flash = 1'b0;
  logic        stall = 1'b0;
  logic        peer = 1'b0;
  logic [63:0] dma_data;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 1;
  int          t_sync = 0;
  int          gap = 0;
  logic [31:0] v;
  logic [3:0]  cards [3] = '{4'h0, 4'h6, 4'h9};

  always #5 clk = ~clk;

  // A ramp on the sample input, so captured words show their spacing.
  always @(posedge clk) adc <= adc + 64'h1;

  // Distance in cycles from a sync pulse to the following sample strobe.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pin_out) t_sync <= cyc;
    if (strobe && t_sync != 0) begin
      gap    <= cyc - t_sync;
      t_sync <= 0;
    end
  end

  dat_engine dut (.core_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .adc_data_in(adc),
    .external_trigger_input_in(ext), .sync_bus_trigger_pin_in(line),
    .sync_bus_trigger_pin_out(pin_out), .sync_bus_trigger_pin_oe_out(oe),
    .card_switch_in(card), .flash_config_switch_in(flash), .recovery_boot_out(recov),
    .dma_data_out(dma_data), .dma_valid_out(dma_valid), .dma_ready_in(dma_ready),
    .sample_strobe_out(strobe));
  dat_far_end far (.clk_in(clk), .rstn_in(rstn), .dma_data_in(dma_data),
    .dma_valid_in(dma_valid), .stall_in(stall), .peer_fire_in(peer), .dut_oe_in(oe),
    .dut_pin_in(pin_out), .dma_ready_out(dma_ready), .sync_line_out(line));

  // ----------------------------------------------------------------------
  // Access tasks and comparisons
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask
  // Polls the state field until it matches or the read budget runs out.
  task automatic wait_state(input logic [3:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      addr <= DAT_REG_STATUS;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
      if (v[3:0] === s) break;
    end
    chk({28'h0, v[3:0]}, {28'h0, s}, "engine state");
  endtask
  task automatic pulse_peer();
    @(posedge clk);
    peer <= 1'b1;
    repeat (2) @(posedge clk);
    peer <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic chk_trace(input int base, input int n, input logic [31:0] step);
    for (int i = 1; i < n; i++) begin
      chk(32'(far.got[base+i] - far.got[base+i-1]), step, "sample spacing");
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rchk(DAT_REG_STATUS, 32'h0000_0F11, "status after reset");
    foreach (cards[i]) begin
      @(posedge clk);
      card  <= cards[i];
      flash <= ~flash;
      repeat (2) @(posedge clk);
      rchk(DAT_REG_STATUS, {19'h0, flash, card, 8'h11}, "card and recovery");
      chk({31'h0, recov}, {31'h0, flash}, "recovery output");
    end
    rchk(4'hF, 32'h0, "unmapped read");
    wr(DAT_REG_INTERVAL, 32'h0);
    rchk(DAT_REG_INTERVAL, 32'h1, "interval floor");
    wr(DAT_REG_CTRL, 32'h2);
    repeat (8) @(posedge clk);
    chk(far.got.size(), 0, "trigger while idle");
    // Post mode at full rate, then a late trigger once finished.
    wr(DAT_REG_COUNT, 32'h4);
    wr(DAT_REG_RETRIG, 32'h1);
    wr(DAT_REG_CTRL, 32'h1);
    wr(DAT_REG_CTRL, 32'h2);
    wait_state(4'h1, 40);
    chk(far.got.size(), 4, "post mode words");
    chk(gap, 1, "post mode first sample");
    chk_trace(0, 4, 1);
    // The captured counter clears when a trace completes.
    rchk(DAT_REG_CAPTURED, 32'h0, "captured count");
    rchk(DAT_REG_TRACES, 32'h1, "traces done");
    wr(DAT_REG_CTRL, 32'h2);
    repeat (10) @(posedge clk);
    chk(far.got.size(), 4, "trigger after last trace");
    // Three traces from the sync line, one trigger too early, DMA stalling.
    wr(DAT_REG_INTERVAL, 32'h3);
    stall <= 1'b1;
    wr(DAT_REG_COUNT, 32'h3);
    wr(DAT_REG_RETRIG, 32'h3);
    wr(DAT_REG_CTRL, 32'h21);
    @(posedge clk);
    peer <= 1'b1;
    repeat (2) @(posedge clk);
    peer <= 1'b0;
    repeat (2) @(posedge clk);
    pulse_peer();
    pulse_peer();
    wait_state(4'h2, 4);
    pulse_peer();
    wait_state(4'h1, 20);
    repeat (40) @(posedge clk);
    chk(far.got.size(), 13, "retrigger words");
    for (int t = 4; t < 13; t += 3) chk_trace(t, 3, 3);
    stall <= 1'b0;
    // Delayed mode from the front trigger, sync pin driven by this card.
    wr(DAT_REG_DELAY, 32'h5);
    wr(DAT_REG_COUNT, 32'h2);
    wr(DAT_REG_RETRIG, 32'h1);
    wr(DAT_REG_CTRL, 32'hC9);
    @(posedge clk);
    chk({31'h0, oe}, 32'h1, "sync pin driven");
    ext <= 1'b1;
    repeat (3) @(posedge clk);
    ext <= 1'b0;
    wait_state(4'h1, 40);
    repeat (4) @(posedge clk);
    chk(gap, 6, "trigger delay");
    chk(far.got.size(), 15, "delayed mode words");
    // A falling front edge starts a long trace that an abort cuts short.
    wr(DAT_REG_COUNT, 32'h8);
    ext <= 1'b1;
    wr(DAT_REG_CTRL, 32'h19);
    ext <= 1'b0;
    wait_state(4'h8, 4);
    wr(DAT_REG_CTRL, 32'h4);
    wait_state(4'h1, 2);
    chk(far.got.size(), 16, "words before abort");
    tally_and_finish();
  end

  // Cuts a hang short well beyond the few hundred cycles the tests need.
  initial begin
    #300000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule

`default_nettype wire
